// File: hw/timer_pkg.sv
package timer_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PWM_W = 10;
    localparam int PRESCALE_W = 14;
    localparam int NUM_TAPS = 15;

    // register offsets
    localparam logic [3:0] OFF_LOW_CTRL = 4'h0;
    localparam logic [3:0] OFF_LOW_DATA = 4'h1;
    localparam logic [3:0] OFF_LOW_CNT = 4'h2;
    localparam logic [3:0] OFF_HIGH_CTRL = 4'h3;
    localparam logic [3:0] OFF_HIGH_DATA = 4'h4;
    localparam logic [3:0] OFF_HIGH_CNT = 4'h5;
    localparam logic [3:0] OFF_DUTY_A = 4'h6;
    localparam logic [3:0] OFF_DUTY_B = 4'h7;
    localparam logic [3:0] OFF_DUTY_C = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'h9;

    // low_timer_control fields
    localparam int LC_CLK_LSB = 0;
    localparam int LC_CAP_BIT = 3;
    localparam int LC_CLR_BIT = 4;
    // high_timer_control fields
    localparam int HC_CLK_LSB = 0;
    localparam int HC_CLR_BIT = 4;
    localparam int HC_CAP_BIT = 5;
    localparam int HC_PWM_BIT = 6;
    localparam int HC_CASCADE_BIT = 7;
    // status fields
    localparam int ST_LOW_FLAG = 0;
    localparam int ST_HIGH_FLAG = 1;
    localparam int ST_MODE_LSB = 2;
    localparam int ST_EC_BIT = 7;

    // reset values
    localparam logic [7:0] LOW_CTRL_RST = 8'h00;
    localparam logic [7:0] HIGH_CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] DUTY_RST = 8'h00;

    // clock select codes
    localparam logic [2:0] LOW_SEL_EXT = 3'h7;
    localparam logic [3:0] HIGH_SEL_LOW_CLK = 4'hf;

    typedef enum logic [4:0] {
        MODE_DUAL8 = 5'h01,
        MODE_CAP8 = 5'h02,
        MODE_T16 = 5'h04,
        MODE_CAP16 = 5'h08,
        MODE_PWM10 = 5'h10
    } timer_mode_t;

endpackage : timer_pkg

// File: hw/clk_prescaler.sv
`timescale 1ns/10ps
module clk_prescaler (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // tap k pulses once every 2**k cycles
    output logic [timer_pkg::NUM_TAPS-1:0] tap_tick
);
    import timer_pkg::*;

    logic [PRESCALE_W-1:0] div_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    assign tap_tick[0] = 1'b1;

    genvar k;
    generate
        for (k = 1; k < NUM_TAPS; k++) begin : g_tap
            assign tap_tick[k] = &div_r[k-1:0];
        end
    endgenerate

endmodule : clk_prescaler

// File: hw/dual_8bit_cascadable_timer.sv
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
// Overview of operation
// - two counters run as two 8-bit timers or one 16-bit timer
// - mode comes from cascade, both capture bits and pwm enable
// - low counter clocks from /2../2048 prescale or external pin
// - high counter clocks from /1../16384 prescale or low clock
// - external pin reaches the high counter only through the low clock
// - external clock counts on rising edges, synchronised first
// - dual mode: each counter matching its data raises its interrupt
// - dual timer mode: each output pin toggles on its match
// - 16-bit mode counts up from zero to data, then clears
// - 16-bit match raises only the low interrupt
// - low timer is the low byte, high timer the high byte
// - 16-bit mode counts on the low timer's selected clock
// - capture mode copies counter on its capture input event
// - 16-bit timer mode: low output shows the compare result
// - pwm mode drives six outputs as three complementary pairs
// - a match clears the counter, in capture mode too
// - capture mode: data reads give capture, writes update compare
// - capture mode: no toggling waveform on the output pins
module dual_8bit_cascadable_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [timer_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [timer_pkg::DATA_W-1:0] reg_rd_data,
    // pins
    input wire logic external_count_clock,
    input wire logic low_capture_event_in,
    input wire logic high_capture_event_in,
    output logic low_match_output,
    output logic high_match_output,
    // interrupt pulses
    output logic low_match_irq,
    output logic high_match_irq,
    // pwm channels
    output logic pwm_ch_a_true,
    output logic pwm_ch_a_comp,
    output logic pwm_ch_b_true,
    output logic pwm_ch_b_comp,
    output logic pwm_ch_c_true,
    output logic pwm_ch_c_comp
);
    import timer_pkg::*;

    function automatic timer_mode_t decode_mode(input logic cascade,
            input logic lcap, input logic hcap, input logic pwm);
        timer_mode_t m;
        m = MODE_DUAL8;
        if (cascade) begin
            m = (lcap && hcap) ? MODE_CAP16 : MODE_T16;
        end else if (pwm) begin
            m = MODE_PWM10;
        end else if (lcap && hcap) begin
            m = MODE_CAP8;
        end
        return m;
    endfunction : decode_mode

    // register state
    logic [7:0] low_ctrl_r;
    logic [7:0] high_ctrl_r;
    logic [7:0] low_compare_data;
    logic [7:0] high_compare_data;
    logic [7:0] low_capture_value;
    logic [7:0] high_capture_value;
    logic [7:0] duty_a_r;
    logic [7:0] duty_b_r;
    logic [7:0] duty_c_r;
    logic low_flag_r;
    logic high_flag_r;
    logic [7:0] low_counter;
    logic [7:0] high_counter;
    logic [7:0] low_cnt_nxt;
    logic [7:0] high_cnt_nxt;
    logic [PWM_W-1:0] pwm_cnt_r;
    logic [7:0] rd_data_r;

    // pin sampling
    logic ec_sync1_r;
    logic ec_sync2_r;
    logic ec_prev_r;
    logic low_ev_prev_r;
    logic high_ev_prev_r;

    // output flops
    logic low_out_r;
    logic high_out_r;
    logic low_irq_r;
    logic high_irq_r;
    logic [5:0] pwm_out_r;

    logic [NUM_TAPS-1:0] tap_tick;

    clk_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .rst(rst),
        .tap_tick(tap_tick)
    );

    // control field decode
    wire [2:0] low_clock_select = low_ctrl_r[LC_CLK_LSB +: 3];
    wire low_capture_mode_sel = low_ctrl_r[LC_CAP_BIT];
    wire [3:0] high_clock_select = high_ctrl_r[HC_CLK_LSB +: 4];
    wire high_capture_mode_sel = high_ctrl_r[HC_CAP_BIT];
    wire pwm_mode_enable = high_ctrl_r[HC_PWM_BIT];
    wire cascade_enable = high_ctrl_r[HC_CASCADE_BIT];

    timer_mode_t mode;
    assign mode = decode_mode(cascade_enable, low_capture_mode_sel,
                              high_capture_mode_sel, pwm_mode_enable);
    wire is_wide = (mode == MODE_T16) || (mode == MODE_CAP16);
    wire is_cap = (mode == MODE_CAP8) || (mode == MODE_CAP16);

    wire ec_rise = ec_sync2_r & ~ec_prev_r;

    logic low_tick;
    always_comb begin
        case (low_clock_select)
            3'h0: low_tick = tap_tick[11];
            3'h1: low_tick = tap_tick[9];
            3'h2: low_tick = tap_tick[7];
            3'h3: low_tick = tap_tick[5];
            3'h4: low_tick = tap_tick[3];
            3'h5: low_tick = tap_tick[2];
            3'h6: low_tick = tap_tick[1];
            default: low_tick = ec_rise;
        endcase
    end

    // high clock: prescale taps or the low clock
    // external pin reaches this mux only through the low clock
    // all-ones code shares the low clock
    wire high_tick = (high_clock_select == HIGH_SEL_LOW_CLK) ? low_tick :
                     tap_tick[high_clock_select];

    // low byte from low timer, high byte from high timer
    wire [15:0] cnt16 = {high_counter, low_counter};
    wire [15:0] data16 = {high_compare_data, low_compare_data};
    wire wide_eq = (cnt16 == data16);
    wire low_eq = (low_counter == low_compare_data);
    wire high_eq = (high_counter == high_compare_data);

    // register strobes
    wire wr_low_ctrl = reg_wr && (reg_addr == OFF_LOW_CTRL);
    wire wr_high_ctrl = reg_wr && (reg_addr == OFF_HIGH_CTRL);
    wire wr_status = reg_wr && (reg_addr == OFF_STATUS);
    wire low_clr = wr_low_ctrl && reg_wr_data[LC_CLR_BIT];
    wire high_clr = wr_high_ctrl && reg_wr_data[HC_CLR_BIT];

    // counter advance and match
    logic low_match;
    logic high_match;
    always_comb begin
        low_cnt_nxt = low_counter;
        high_cnt_nxt = high_counter;
        low_match = 1'b0;
        high_match = 1'b0;
        if (is_wide) begin
            // combined counter steps on the low clock
            if (low_tick) begin
                if (wide_eq) begin
                    {high_cnt_nxt, low_cnt_nxt} = 16'h0000;
                    low_match = 1'b1;
                end else begin
                    {high_cnt_nxt, low_cnt_nxt} = cnt16 + 16'h0001;
                end
            end
            if (low_clr || high_clr) begin
                {high_cnt_nxt, low_cnt_nxt} = 16'h0000;
            end
        end else begin
            if (low_tick) begin
                if (low_eq) begin
                    low_cnt_nxt = 8'h00;
                    low_match = 1'b1;
                end else begin
                    low_cnt_nxt = low_counter + 8'h01;
                end
            end
            if (high_tick && (mode != MODE_PWM10)) begin
                if (high_eq) begin
                    high_cnt_nxt = 8'h00;
                    high_match = 1'b1;
                end else begin
                    high_cnt_nxt = high_counter + 8'h01;
                end
            end
            if (low_clr) begin
                low_cnt_nxt = 8'h00;
            end
            if (high_clr) begin
                high_cnt_nxt = 8'h00;
            end
        end
    end

    // pwm period end
    wire pwm_wrap = (mode == MODE_PWM10) && high_tick && (&pwm_cnt_r);

    // capture edges
    wire low_cap_ev = low_capture_event_in & ~low_ev_prev_r;
    wire high_cap_ev = high_capture_event_in & ~high_ev_prev_r;

    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            OFF_LOW_CTRL: rd_mux = low_ctrl_r & 8'h0f;
            // capture mode reads the captured value
            OFF_LOW_DATA: rd_mux = is_cap ? low_capture_value :
                                   low_compare_data;
            OFF_LOW_CNT: rd_mux = low_counter;
            OFF_HIGH_CTRL: rd_mux = high_ctrl_r & 8'hef;
            OFF_HIGH_DATA: rd_mux = is_cap ? high_capture_value :
                                    high_compare_data;
            OFF_HIGH_CNT: rd_mux = high_counter;
            OFF_DUTY_A: rd_mux = duty_a_r;
            OFF_DUTY_B: rd_mux = duty_b_r;
            OFF_DUTY_C: rd_mux = duty_c_r;
            OFF_STATUS: rd_mux = {ec_sync2_r, mode, high_flag_r, low_flag_r};
            default: rd_mux = 8'h00;
        endcase
    end

    // register writes
    // reset selects dual 8-bit mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_ctrl_r <= LOW_CTRL_RST;
            high_ctrl_r <= HIGH_CTRL_RST;
            low_compare_data <= DATA_RST;
            high_compare_data <= DATA_RST;
            duty_a_r <= DUTY_RST;
            duty_b_r <= DUTY_RST;
            duty_c_r <= DUTY_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                OFF_LOW_CTRL: low_ctrl_r <= reg_wr_data & 8'h0f;
                OFF_LOW_DATA: low_compare_data <= reg_wr_data;
                OFF_HIGH_CTRL: high_ctrl_r <= reg_wr_data & 8'hef;
                OFF_HIGH_DATA: high_compare_data <= reg_wr_data;
                OFF_DUTY_A: duty_a_r <= reg_wr_data;
                OFF_DUTY_B: duty_b_r <= reg_wr_data;
                OFF_DUTY_C: duty_c_r <= reg_wr_data;
                default: ;
            endcase
        end
    end

    // sticky match flags, set beats clear
    wire low_set = low_match;
    wire high_set = high_match || pwm_wrap;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_flag_r <= 1'b0;
            high_flag_r <= 1'b0;
        end else begin
            low_flag_r <= low_set ||
                (low_flag_r && !(wr_status && reg_wr_data[ST_LOW_FLAG]));
            high_flag_r <= high_set ||
                (high_flag_r && !(wr_status && reg_wr_data[ST_HIGH_FLAG]));
        end
    end

    // counters
    // counters cleared at reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_counter <= 8'h00;
            high_counter <= 8'h00;
        end else begin
            low_counter <= low_cnt_nxt;
            high_counter <= high_cnt_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ec_sync1_r <= 1'b0;
            ec_sync2_r <= 1'b0;
            ec_prev_r <= 1'b0;
            low_ev_prev_r <= 1'b0;
            high_ev_prev_r <= 1'b0;
        end else begin
            ec_sync1_r <= external_count_clock;
            ec_sync2_r <= ec_sync1_r;
            ec_prev_r <= ec_sync2_r;
            low_ev_prev_r <= low_capture_event_in;
            high_ev_prev_r <= high_capture_event_in;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_capture_value <= 8'h00;
            high_capture_value <= 8'h00;
        end else if (mode == MODE_CAP16) begin
            if (low_cap_ev) begin
                low_capture_value <= low_counter;
                high_capture_value <= high_counter;
            end
        end else if (mode == MODE_CAP8) begin
            if (low_cap_ev) begin
                low_capture_value <= low_counter;
            end
            if (high_cap_ev) begin
                high_capture_value <= high_counter;
            end
        end
    end

    // match outputs and interrupts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_out_r <= 1'b0;
            high_out_r <= 1'b0;
            low_irq_r <= 1'b0;
            high_irq_r <= 1'b0;
        end else begin
            // wide mode uses only the low interrupt
            low_irq_r <= low_match;
            high_irq_r <= high_match || pwm_wrap;
            if (mode == MODE_DUAL8) begin
                if (low_match) begin
                    low_out_r <= ~low_out_r;
                end
                if (high_match) begin
                    high_out_r <= ~high_out_r;
                end
            end else if (mode == MODE_T16) begin
                low_out_r <= wide_eq;
                high_out_r <= 1'b0;
            end else begin
                // no waveform in capture or pwm mode
                low_out_r <= 1'b0;
                high_out_r <= 1'b0;
            end
        end
    end

    // 10-bit pwm with three complementary pairs
    wire ch_a = pwm_cnt_r < {duty_a_r, 2'b00};
    wire ch_b = pwm_cnt_r < {duty_b_r, 2'b00};
    wire ch_c = pwm_cnt_r < {duty_c_r, 2'b00};
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_cnt_r <= '0;
            pwm_out_r <= 6'h00;
        end else if (mode == MODE_PWM10) begin
            if (high_tick) begin
                pwm_cnt_r <= pwm_cnt_r + 1'b1;
            end
            pwm_out_r <= {~ch_c, ch_c, ~ch_b, ch_b, ~ch_a, ch_a};
        end else begin
            pwm_cnt_r <= '0;
            pwm_out_r <= 6'h00;
        end
    end

    // read data valid one cycle after the strobe only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rd_data = rd_data_r;
    assign low_match_output = low_out_r;
    assign high_match_output = high_out_r;
    assign low_match_irq = low_irq_r;
    assign high_match_irq = high_irq_r;
    assign pwm_ch_a_true = pwm_out_r[0];
    assign pwm_ch_a_comp = pwm_out_r[1];
    assign pwm_ch_b_true = pwm_out_r[2];
    assign pwm_ch_b_comp = pwm_out_r[3];
    assign pwm_ch_c_true = pwm_out_r[4];
    assign pwm_ch_c_comp = pwm_out_r[5];

endmodule : dual_8bit_cascadable_timer

// File: testbench/ext_pin_model.sv
`timescale 1ns/10ps
module ext_pin_model (
    // clock
    input wire logic ref_clk,
    // pins toward the timer
    output logic external_count_clock,
    output logic low_capture_event_in,
    output logic high_capture_event_in
);
    initial begin
        external_count_clock = 1'b0;
        low_capture_event_in = 1'b0;
        high_capture_event_in = 1'b0;
    end

    // clean rising edges
    // levels last two cycles so the synchroniser cannot miss them
    task pulses(input int cnt);
        repeat (cnt) begin
            @(posedge ref_clk);
            external_count_clock <= 1'b1;
            repeat (2) @(posedge ref_clk);
            external_count_clock <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask : pulses

    task capture(input bit hi);
        @(posedge ref_clk);
        if (hi) begin
            high_capture_event_in <= 1'b1;
        end else begin
            low_capture_event_in <= 1'b1;
        end
        repeat (2) @(posedge ref_clk);
        low_capture_event_in <= 1'b0;
        high_capture_event_in <= 1'b0;
    endtask : capture
endmodule : ext_pin_model

// File: testbench/dual_8bit_cascadable_timer_asserts.sv
`timescale 1ns/10ps
module timer_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [timer_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic reg_wr,
    // pins and interrupts
    input wire logic low_match_output,
    input wire logic high_match_output,
    input wire logic low_match_irq,
    input wire logic high_match_irq,
    // pwm channels
    input wire logic pwm_ch_a_true,
    input wire logic pwm_ch_a_comp,
    input wire logic pwm_ch_b_true,
    input wire logic pwm_ch_b_comp,
    input wire logic pwm_ch_c_true,
    input wire logic pwm_ch_c_comp
);
    import timer_pkg::*;
    logic casc_r, lcap_r, hcap_r, pwm_r;
    logic [3:0] cfg_d1_r, cfg_d2_r;
    wire [3:0] cfg_w = {casc_r, lcap_r, hcap_r, pwm_r};
    // mode counts as settled two cycles after the last control write
    wire settled = (cfg_w == cfg_d1_r) && (cfg_d1_r == cfg_d2_r);
    wire in_dual = !casc_r && !pwm_r && !(lcap_r && hcap_r);
    wire in_pwm = pwm_r && !casc_r;
    wire hit_hi = reg_wr && (reg_addr == OFF_HIGH_CTRL);
    wire hit_lo = reg_wr && (reg_addr == OFF_LOW_CTRL);
    wire pwm_any = pwm_ch_a_true | pwm_ch_a_comp | pwm_ch_b_true |
        pwm_ch_b_comp | pwm_ch_c_true | pwm_ch_c_comp;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {casc_r, lcap_r, hcap_r, pwm_r} <= 4'h0;
            cfg_d1_r <= 4'h0;
            cfg_d2_r <= 4'h0;
        end else begin
            if (hit_hi) begin
                casc_r <= reg_wr_data[HC_CASCADE_BIT];
                hcap_r <= reg_wr_data[HC_CAP_BIT];
                pwm_r <= reg_wr_data[HC_PWM_BIT];
            end
            if (hit_lo) begin
                lcap_r <= reg_wr_data[LC_CAP_BIT];
            end
            cfg_d1_r <= cfg_w;
            cfg_d2_r <= cfg_d1_r;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_low_toggle: assert property (
        settled && in_dual && $changed(low_match_output) |-> low_match_irq)
        else $error("low output moved without a low match");
    chk_high_toggle: assert property (
        settled && in_dual && $changed(high_match_output) |-> high_match_irq)
        else $error("high output moved without a high match");
    chk_wide_no_high: assert property (
        settled && casc_r |-> !high_match_irq)
        else $error("high interrupt in cascaded mode");
    chk_low_quiet: assert property (
        settled && !in_dual && !casc_r |-> !low_match_output)
        else $error("low output active outside its modes");
    chk_high_out_quiet: assert property (
        settled && !in_dual |-> !high_match_output)
        else $error("high output active outside dual timer mode");
    chk_wide_out_eq: assert property (
        settled && casc_r && !(lcap_r && hcap_r) && low_match_irq
        |-> low_match_output)
        else $error("low output not showing the 16-bit compare");
    chk_irq_spacing: assert property (
        low_match_irq |=> !low_match_irq)
        else $error("low interrupt on two cycles running");
    chk_pwm_pairs: assert property (
        settled && in_pwm |-> (pwm_ch_a_comp != pwm_ch_a_true) &&
        (pwm_ch_b_comp != pwm_ch_b_true) && (pwm_ch_c_comp != pwm_ch_c_true))
        else $error("pwm pair not complementary");
    chk_pwm_idle: assert property (
        settled && !in_pwm |-> !pwm_any)
        else $error("pwm channel active outside pwm mode");

    cover property (in_dual && low_match_irq);
    cover property (casc_r && low_match_irq);
    cover property (settled && in_pwm && $rose(pwm_ch_a_true));
endmodule : timer_checker

bind dual_8bit_cascadable_timer timer_checker u_chk (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
    .low_match_output(low_match_output),
    .high_match_output(high_match_output),
    .low_match_irq(low_match_irq), .high_match_irq(high_match_irq),
    .pwm_ch_a_true(pwm_ch_a_true), .pwm_ch_a_comp(pwm_ch_a_comp),
    .pwm_ch_b_true(pwm_ch_b_true), .pwm_ch_b_comp(pwm_ch_b_comp),
    .pwm_ch_c_true(pwm_ch_c_true), .pwm_ch_c_comp(pwm_ch_c_comp)
);

// File: testbench/test_dual_8bit_cascadable_timer.sv
`timescale 1ns/10ps
module test_dual_8bit_cascadable_timer;
    import timer_pkg::*;
    logic ref_clk, rst, reg_wr, reg_rd;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wr_data, reg_rd_data, v, cv;
    logic ext_clk, lcap_in, hcap_in, lo_out, hi_out, lo_irq, hi_irq;
    logic [5:0] pwm;
    logic [15:0] n;
    int error_cnt, n_checks, ca, cb, cc;
    logic [15:0] low_gap [7] = '{16'd2048, 16'd512, 16'd128, 16'd32,
        16'd8, 16'd4, 16'd2};

    dual_8bit_cascadable_timer uut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .external_count_clock(ext_clk),
        .low_capture_event_in(lcap_in), .high_capture_event_in(hcap_in),
        .low_match_output(lo_out), .high_match_output(hi_out),
        .low_match_irq(lo_irq), .high_match_irq(hi_irq),
        .pwm_ch_a_true(pwm[0]), .pwm_ch_a_comp(pwm[1]),
        .pwm_ch_b_true(pwm[2]), .pwm_ch_b_comp(pwm[3]),
        .pwm_ch_c_true(pwm[4]), .pwm_ch_c_comp(pwm[5]));
    ext_pin_model pins (.ref_clk(ref_clk), .external_count_clock(ext_clk),
        .low_capture_event_in(lcap_in), .high_capture_event_in(hcap_in));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        #1950000;
        error_cnt++;
        wrap_up();
    end

    task wrap_up;
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rd_data;
    endtask : rd
    task rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a, v);
        chk({8'h00, v & m}, {8'h00, e});
    endtask : rdc
    // cycles up to and including the next interrupt pulse
    task wait_irq(input bit w);
        n = 16'h0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (!(w ? hi_irq === 1'b1 : lo_irq === 1'b1) && n < 16'd40000);
        if (n >= 16'd40000) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wait_irq
    // skip pulses still launched by the old setting, then time one period
    task gap(input bit w, input logic [15:0] e);
        repeat (2) @(posedge ref_clk);
        wait_irq(w);
        wait_irq(w);
        chk(n, e);
    endtask : gap

    initial begin
        rst = 1'b1;
        reg_addr = '0;
        reg_wr_data = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        error_cnt = 0;
        n_checks = 0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(OFF_STATUS, 8'hff, 8'h04);
        rdc(OFF_LOW_CNT, 8'hff, 8'h00);
        rdc(OFF_LOW_DATA, 8'hff, DATA_RST);
        rdc(OFF_HIGH_CTRL, 8'hff, HIGH_CTRL_RST);
        chk({14'h0, lo_out, hi_out}, 16'h0);
        wr(4'hf, 8'h5a);
        rdc(4'hf, 8'hff, 8'h00);
        wr(OFF_LOW_DATA, 8'h00);
        for (int c = 0; c < 7; c++) begin
            wr(OFF_LOW_CTRL, 8'h10 | c[7:0]);
            gap(1'b0, low_gap[c]);
        end
        wr(OFF_HIGH_DATA, 8'h00);
        // select stays below all-ones while the timers run separately
        for (int k = 0; k < 15; k++) begin
            wr(OFF_HIGH_CTRL, 8'h10 | k[7:0]);
            gap(1'b1, 16'h1 << k);
        end
        wr(OFF_LOW_DATA, 8'h03);
        wr(OFF_LOW_CTRL, 8'h16);
        gap(1'b0, 16'd8);
        v[0] = lo_out;
        wait_irq(1'b0);
        chk({15'h0, lo_out}, {15'h0, ~v[0]});
        wr(OFF_LOW_DATA, 8'h02);
        wr(OFF_HIGH_DATA, 8'h01);
        wr(OFF_HIGH_CTRL, 8'h9f);
        rdc(OFF_STATUS, 8'h7c, 8'h10);
        gap(1'b0, 16'd518);
        chk({15'h0, lo_out}, 16'h1);
        @(posedge ref_clk);
        #1;
        chk({15'h0, lo_out}, 16'h0);
        wr(OFF_HIGH_DATA, 8'hff);
        wr(OFF_LOW_DATA, 8'hff);
        wr(OFF_LOW_CTRL, 8'h1f);
        wr(OFF_HIGH_CTRL, 8'h30);
        rdc(OFF_STATUS, 8'h7c, 8'h08);
        pins.pulses(3);
        pins.capture(1'b0);
        rdc(OFF_LOW_DATA, 8'hff, 8'h03);
        rd(OFF_HIGH_CNT, v);
        cv = v + 8'h02;
        pins.capture(1'b1);
        rdc(OFF_HIGH_DATA, 8'hff, cv);
        wr(OFF_HIGH_DATA, 8'h03);
        gap(1'b1, 16'd4);
        rdc(OFF_HIGH_DATA, 8'hff, cv);
        chk({14'h0, lo_out, hi_out}, 16'h0);
        wr(OFF_HIGH_CTRL, 8'hbf);
        rdc(OFF_STATUS, 8'h7c, 8'h20);
        wr(OFF_LOW_CTRL, 8'h16);
        wr(OFF_HIGH_CTRL, 8'h40);
        rdc(OFF_STATUS, 8'h7c, 8'h40);
        wr(OFF_DUTY_A, 8'h40);
        wr(OFF_DUTY_B, 8'h00);
        wr(OFF_DUTY_C, 8'hff);
        gap(1'b1, 16'd1024);
        ca = 0;
        cb = 0;
        cc = 0;
        repeat (1024) begin
            @(posedge ref_clk);
            #1;
            ca += int'(pwm[0]);
            cb += int'(pwm[2]);
            cc += int'(pwm[4]);
        end
        chk(ca[15:0], 16'd256);
        chk(cb[15:0], 16'd0);
        chk(cc[15:0], 16'd1020);
        wrap_up();
    end
endmodule : test_dual_8bit_cascadable_timer
